// ==== logic/jfp_pkg.sv ====
package jfp_pkg;

  localparam int IR_WIDTH = 4;
  localparam int CMD_WIDTH = 15;
  localparam int BYTE_WIDTH = 8;
  localparam int WORD_WIDTH = 16;

  localparam logic [IR_WIDTH-1:0] OP_COMMAND = 4'h5;
  localparam logic [IR_WIDTH-1:0] OP_PAGE_LOAD = 4'h6;
  localparam logic [IR_WIDTH-1:0] OP_PAGE_READ = 4'h7;
  localparam logic [IR_WIDTH-1:0] OP_BYPASS = 4'hf;
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VALUE = 4'h1;
  localparam logic [IR_WIDTH-1:0] IR_RESET_VALUE = OP_BYPASS;
  localparam logic [CMD_WIDTH-1:0] CMD_RESET_VALUE = 15'h0000;
  localparam logic [BYTE_WIDTH-1:0] BYTE_RESET_VALUE = 8'h00;

  // Page write is issued PAGE_WR_DELAY + 1 core cycles after the load_update strobe
  localparam int PAGE_WR_LIMIT_TCK = 11;
  localparam int PAGE_WR_DELAY = 2;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jfp_tap_state_type;

  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_COMMAND, SEL_PAGE_LOAD, SEL_PAGE_READ
  } jfp_dr_sel_type;

endpackage

// ==== logic/jfp_if.sv ====
`timescale 1ns/1ps
interface jfp_tap_if;
  import jfp_pkg::*;
  logic tck_rise;
  logic tck_fall;
  logic tdi;
  jfp_tap_state_type state;
  modport link (output tck_rise, output tck_fall, output tdi, output state);
  modport core (input tck_rise, input tck_fall, input tdi, input state);
endinterface

interface jfp_page_if;
  logic restart;
  logic load_update;
  logic read_capture;
  logic hi_sel;
  logic pc_inc;
  modport seq (input restart, input load_update, input read_capture, output hi_sel, output pc_inc);
  modport core (output restart, output load_update, output read_capture, input hi_sel, input pc_inc);
endinterface

// ==== logic/jfp_link_sync.sv ====
`timescale 1ns/1ps
module jfp_link_sync
  import jfp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Link pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  // To core
  jfp_tap_if.link tap
);

  logic [1:0] tck_sync;
  logic [1:0] tms_sync;
  logic [1:0] tdi_sync;
  logic tck_prev;
  logic tms_prev;

  function automatic jfp_tap_state_type tap_next(jfp_tap_state_type s, logic m);
    unique case (s)
      TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
    endcase
  endfunction

  // All three pins share latency, so tms and tdi stay aligned with the edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tck_sync <= 2'h0;
      tms_sync <= 2'h3;
      tdi_sync <= 2'h0;
      tck_prev <= 1'b0;
      tms_prev <= 1'b1;
    end else begin
      tck_sync <= {tck_sync[0], tck};
      tms_sync <= {tms_sync[0], tms};
      tdi_sync <= {tdi_sync[0], tdi};
      tck_prev <= tck_sync[1];
      tms_prev <= tms_sync[1];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tap.tck_rise <= 1'b0;
      tap.tck_fall <= 1'b0;
      tap.tdi <= 1'b0;
    end else begin
      tap.tck_rise <= tck_sync[1] & ~tck_prev;
      tap.tck_fall <= ~tck_sync[1] & tck_prev;
      tap.tdi <= tdi_sync[1];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tap.state <= TAP_RESET;
    // Moves after the rise pulse, so the pulse sees the state it acts in
    end else if (tap.tck_rise) begin
      tap.state <= tap_next(tap.state, tms_prev);
    end
  end

endmodule

// ==== logic/jfp_page_seq.sv ====
`timescale 1ns/1ps
module jfp_page_seq
  import jfp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // From core
  jfp_page_if.seq pg
);

  logic first_done;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pg.hi_sel <= 1'b0;
      first_done <= 1'b0;
    end else if (pg.restart) begin
      pg.hi_sel <= 1'b0;
      first_done <= 1'b0;
    end else begin
      if (pg.load_update || pg.read_capture) begin
        pg.hi_sel <= ~pg.hi_sel;
      end
      if (pg.load_update) begin
        first_done <= 1'b1;
      end
    end
  end

  // Uses the byte select before its toggle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pg.pc_inc <= 1'b0;
    end else begin
      pg.pc_inc <= (pg.load_update & ~pg.hi_sel & first_done & ~pg.restart)
        | (pg.read_capture & pg.hi_sel & ~pg.restart);
    end
  end

endmodule

// ==== logic/jfp_top.sv ====
`timescale 1ns/1ps
module jfp_top
  import jfp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Link pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Programming mode from the unlock logic
  input wire logic prog_mode,
  // Command path to flash programming logic
  input wire logic [CMD_WIDTH-1:0] cmd_result,
  output logic [CMD_WIDTH-1:0] cmd_word,
  output logic cmd_apply,
  output logic cmd_exec,
  // Page buffer and program counter
  input wire logic [WORD_WIDTH-1:0] flash_word,
  output logic [BYTE_WIDTH-1:0] page_data,
  output logic page_wr,
  output logic page_wr_high,
  output logic pc_inc
);

  jfp_tap_if tap ();
  jfp_page_if pg ();

  logic [IR_WIDTH-1:0] ir_sr;
  logic [IR_WIDTH-1:0] ir;
  logic [CMD_WIDTH-1:0] cmd_sr;
  logic bypass_sr;
  logic exec_done;
  logic [PAGE_WR_DELAY-1:0] wr_pipe;
  logic wr_high_hold;
  jfp_dr_sel_type sel;
  logic rise;
  logic fall;

  jfp_link_sync u_link (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tap(tap.link)
  );

  jfp_page_seq u_page (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pg(pg.seq)
  );

  // Outside programming mode the opcodes fall back to bypass
  function automatic jfp_dr_sel_type dr_select(logic [IR_WIDTH-1:0] op, logic enabled);
    dr_select = SEL_BYPASS;
    if (enabled) begin
      if (op == OP_COMMAND) begin
        dr_select = SEL_COMMAND;
      end else if (op == OP_PAGE_LOAD) begin
        dr_select = SEL_PAGE_LOAD;
      end else if (op == OP_PAGE_READ) begin
        dr_select = SEL_PAGE_READ;
      end
    end
  endfunction

  assign rise = tap.tck_rise;
  assign fall = tap.tck_fall;
  assign sel = dr_select(ir, prog_mode);

  // Instruction register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ir_sr <= IR_RESET_VALUE;
    end else if (rise && tap.state == TAP_CAP_IR) begin
      ir_sr <= IR_CAPTURE_VALUE;
    end else if (rise && tap.state == TAP_SHIFT_IR) begin
      ir_sr <= {tap.tdi, ir_sr[IR_WIDTH-1:1]};
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ir <= IR_RESET_VALUE;
    end else if (tap.state == TAP_RESET) begin
      ir <= IR_RESET_VALUE;
    end else if (fall && tap.state == TAP_UPD_IR) begin
      ir <= ir_sr;
    end
  end

  // Command shift register; its low byte doubles as the data byte
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_sr <= CMD_RESET_VALUE;
    end else if (rise && tap.state == TAP_CAP_DR) begin
      if (sel == SEL_COMMAND) begin
        cmd_sr <= cmd_result;
      end else if (sel == SEL_PAGE_READ) begin
        cmd_sr[BYTE_WIDTH-1:0] <= pg.hi_sel ? flash_word[WORD_WIDTH-1:BYTE_WIDTH]
                                            : flash_word[BYTE_WIDTH-1:0];
      end
    end else if (rise && tap.state == TAP_SHIFT_DR) begin
      if (sel == SEL_COMMAND) begin
        cmd_sr <= {tap.tdi, cmd_sr[CMD_WIDTH-1:1]};
      end else if (sel == SEL_PAGE_LOAD || sel == SEL_PAGE_READ) begin
        cmd_sr[BYTE_WIDTH-1:0] <= {tap.tdi, cmd_sr[BYTE_WIDTH-1:1]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bypass_sr <= 1'b0;
    end else if (rise && tap.state == TAP_CAP_DR) begin
      bypass_sr <= 1'b0;
    end else if (rise && tap.state == TAP_SHIFT_DR) begin
      bypass_sr <= tap.tdi;
    end
  end

  // Output changes on the falling edge so the host samples a settled bit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (fall) begin
      tdo_oe <= tap.state == TAP_SHIFT_IR || tap.state == TAP_SHIFT_DR;
      if (tap.state == TAP_SHIFT_IR) begin
        tdo <= ir_sr[0];
      end else if (tap.state == TAP_SHIFT_DR) begin
        tdo <= sel == SEL_BYPASS ? bypass_sr : cmd_sr[0];
      end
    end
  end

  // Command apply and execute
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_word <= CMD_RESET_VALUE;
      cmd_apply <= 1'b0;
    end else begin
      cmd_apply <= 1'b0;
      if (fall && tap.state == TAP_UPD_DR && sel == SEL_COMMAND) begin
        cmd_word <= cmd_sr;
        cmd_apply <= 1'b1;
      end
    end
  end

  // One pulse per visit to idle with the command opcode selected, however long the host stays there
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_exec <= 1'b0;
      exec_done <= 1'b0;
    end else begin
      cmd_exec <= 1'b0;
      if (tap.state != TAP_IDLE) begin
        exec_done <= 1'b0;
      end else if (rise && !exec_done && sel == SEL_COMMAND) begin
        cmd_exec <= 1'b1;
        exec_done <= 1'b1;
      end
    end
  end

  // Page sequencing strobes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pg.restart <= 1'b0;
      pg.load_update <= 1'b0;
      pg.read_capture <= 1'b0;
    end else begin
      pg.restart <= (fall && tap.state == TAP_UPD_IR) || tap.state == TAP_RESET;
      pg.load_update <= fall && tap.state == TAP_UPD_DR && sel == SEL_PAGE_LOAD;
      pg.read_capture <= rise && tap.state == TAP_CAP_DR && sel == SEL_PAGE_READ;
    end
  end

  assign pc_inc = pg.pc_inc;

  // Holding register and delayed write, after any pre-increment
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      page_data <= BYTE_RESET_VALUE;
    end else if (fall && tap.state == TAP_UPD_DR && sel == SEL_PAGE_LOAD) begin
      page_data <= cmd_sr[BYTE_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pipe <= '0;
      wr_high_hold <= 1'b0;
      page_wr <= 1'b0;
      page_wr_high <= 1'b0;
    end else begin
      wr_pipe <= {wr_pipe[PAGE_WR_DELAY-2:0], pg.load_update};
      if (pg.load_update) begin
        wr_high_hold <= pg.hi_sel;
      end
      page_wr <= wr_pipe[PAGE_WR_DELAY-1];
      if (wr_pipe[PAGE_WR_DELAY-1]) begin
        page_wr_high <= wr_high_hold;
      end
    end
  end

endmodule

// ==== sim/jfp_chk.sv ====
`timescale 1ns/1ps
module jfp_chk
  import jfp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Link pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  // Flash side
  input wire logic prog_mode,
  input wire logic [CMD_WIDTH-1:0] cmd_result,
  input wire logic [CMD_WIDTH-1:0] cmd_word,
  input wire logic cmd_apply,
  input wire logic cmd_exec,
  input wire logic [WORD_WIDTH-1:0] flash_word,
  input wire logic [BYTE_WIDTH-1:0] page_data,
  input wire logic page_wr,
  input wire logic page_wr_high,
  input wire logic pc_inc
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_apply_one_pulse: assert property (cmd_apply |=> !cmd_apply) else $error("cmd_apply too long");
  a_word_with_apply: assert property ($changed(cmd_word) |-> cmd_apply) else $error("cmd_word moved alone");
  a_exec_one_pulse: assert property (cmd_exec |=> !cmd_exec) else $error("cmd_exec too long");
  a_write_one_pulse: assert property (page_wr |=> !page_wr) else $error("page_wr too long");
  a_pc_one_pulse: assert property (pc_inc |=> !pc_inc) else $error("pc_inc too long");
  a_data_then_write: assert property ($changed(page_data) |-> ##3 page_wr) else $error("page_wr late");
  // Shifting moves tdo only on a falling link clock
  a_tdo_at_fall: assert property ($changed(tdo) |-> !$past(tck, 2)) else $error("tdo moved off fall");
  a_tdo_in_shift: assert property ($changed(tdo) |-> tdo_oe) else $error("tdo moved outside shift");
  a_locked_quiet: assert property (!prog_mode && !$past(prog_mode, 8) |-> !cmd_apply && !page_wr && !pc_inc)
    else $error("action while locked");
endmodule

// ==== sim/jfp_host.sv ====
`timescale 1ns/1ps
module jfp_host (
  // Clock
  input wire logic core_clk,
  // Link pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  logic seen;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Clock rests low between frames; 8 core cycles per half period
  task tick(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge core_clk);
    tck <= 1'b1;
    seen = tdo;
    repeat (8) @(posedge core_clk);
    tck <= 1'b0;
  endtask
  // Unused tdi is inverted so a stale bit cannot pass as data
  task idle(input int n);
    repeat (n) tick(1'b0, ~tdi);
  endtask
  task shift(input int n, input logic [15:0] din, output logic [15:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i]);
      dout[i] = seen;
    end
    tick(1'b1, ~tdi);
    tick(1'b0, ~tdi);
  endtask
  task ir(input logic [3:0] op, output logic [15:0] dout);
    tick(1'b1, ~tdi);
    tick(1'b1, ~tdi);
    tick(1'b0, ~tdi);
    tick(1'b0, ~tdi);
    shift(4, {12'h000, op}, dout);
  endtask
  // Updates are at least n + 5 TCK apart, 13 for a byte, above the write window
  task dr(input int n, input logic [15:0] din, output logic [15:0] dout);
    tick(1'b1, ~tdi);
    tick(1'b0, ~tdi);
    tick(1'b0, ~tdi);
    shift(n, din, dout);
  endtask
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
  import jfp_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic prog_mode = 1'b0;
  logic [CMD_WIDTH-1:0] cmd_result = 15'h2a5c;
  logic [WORD_WIDTH-1:0] flash_word = 16'hc3a7;
  logic tck, tms, tdi, tdo, tdo_oe, cmd_apply, cmd_exec, page_wr, page_wr_high, pc_inc;
  logic [CMD_WIDTH-1:0] cmd_word;
  logic [BYTE_WIDTH-1:0] page_data;
  logic [15:0] q;
  logic [7:0] highs = 8'h00;
  int errors = 0;
  int tests_run = 0;
  int execs = 0;
  int incs = 0;
  int wrs = 0;
  int applies = 0;
  always #5 core_clk = ~core_clk;
  jfp_top uut (.core_clk(core_clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .prog_mode(prog_mode), .cmd_result(cmd_result), .cmd_word(cmd_word),
    .cmd_apply(cmd_apply), .cmd_exec(cmd_exec), .flash_word(flash_word), .page_data(page_data),
    .page_wr(page_wr), .page_wr_high(page_wr_high), .pc_inc(pc_inc));
  jfp_host host (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  always @(posedge core_clk) begin
    if (cmd_exec === 1'b1) execs++;
    if (pc_inc === 1'b1) incs++;
    if (cmd_apply === 1'b1) applies++;
    if (page_wr === 1'b1) begin
      wrs++;
      highs = {highs[6:0], page_wr_high};
    end
  end
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task end_sim;
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task t_reset;
    check("oe", tdo_oe, 0);
    check("word", cmd_word, 0);
    check("data", page_data, 0);
  endtask
  // Locked device: command opcode falls back to a one-bit bypass
  task t_bypass;
    host.ir(OP_COMMAND, q);
    check("ir cap", q[3:0], IR_CAPTURE_VALUE);
    host.dr(2, 16'h0001, q);
    check("bypass", q[1:0], 2'b10);
    check("locked word", cmd_word, 0);
  endtask
  task t_command;
    prog_mode <= 1'b1;
    host.ir(OP_COMMAND, q);
    host.dr(15, 16'h1b3e, q);
    check("result", q[14:0], cmd_result);
    check("word", cmd_word, 15'h1b3e);
    check("apply", applies, 1);
    execs = 0;
    host.idle(2);
    check("exec", execs, 1);
    host.dr(16, 16'h8001, q);
    check("len", q[15], 1'b1);
    check("word lsb", cmd_word, 15'h4000);
  endtask
  task t_load;
    incs = 0;
    wrs = 0;
    host.ir(OP_PAGE_LOAD, q);
    for (int i = 0; i < 4; i++) begin
      host.dr(8, 16'h0090 + i, q);
      check("hold", page_data, 8'h90 + i);
      check("writes", wrs, i + 1);
    end
    check("sides", highs[3:0], 4'b0101);
    check("pre inc", incs, 1);
    host.ir(OP_PAGE_LOAD, q);
    host.dr(8, 16'h003c, q);
    check("restart", highs[0], 1'b0);
    check("first inc", incs, 1);
  endtask
  task t_read;
    incs = 0;
    host.ir(OP_PAGE_READ, q);
    for (int i = 0; i < 4; i++) begin
      host.dr(8, 16'h0000, q);
      check("rd byte", q[7:0], i[0] ? 8'hc3 : 8'ha7);
      check("post inc", incs, (i + 1) / 2);
    end
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset;
    host.idle(1);
    t_bypass;
    t_command;
    t_load;
    t_read;
    end_sim;
  end
  initial begin
    #200000;
    errors++;
    end_sim;
  end
endmodule
bind jfp_top jfp_chk chk (.core_clk(core_clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
  .tdo_oe(tdo_oe), .prog_mode(prog_mode), .cmd_result(cmd_result), .cmd_word(cmd_word),
  .cmd_apply(cmd_apply), .cmd_exec(cmd_exec), .flash_word(flash_word), .page_data(page_data),
  .page_wr(page_wr), .page_wr_high(page_wr_high), .pc_inc(pc_inc));
